// ---- inc/cbu_defines.svh ----
// Purpose: Constants for the conditional branch unit
// Assumes: 16-bit instruction word, 21-bit byte program counter
// Notes: Opcode high bytes, phase counts and reset values
`ifndef CBU_DEFINES_SVH
`define CBU_DEFINES_SVH
`define CBU_OP_NEG_SET 8'hE6
`define CBU_OP_CARRY_CLR 8'hE3
`define CBU_OP_NEG_CLR 8'hE7
`define CBU_OP_OVF_CLR 8'hE5
`define CBU_OP_ZERO_CLR 8'hE1
`define CBU_PC_W 21
`define CBU_PC_RST 21'h000000
`define CBU_WORD_BYTES 21'h000002
`define CBU_PHASES 2'h3
`define CBU_FLAG_N 3
`define CBU_FLAG_OV 2
`define CBU_FLAG_Z 1
`define CBU_FLAG_C 0
`endif

// ---- inc/cbu_pkg.sv ----
// Purpose: Types for the conditional branch unit
// Assumes: Four phases per instruction cycle
// Notes: Phase and cycle-state enums
package cbu_pkg;
   typedef enum logic [1:0] {
      CBU_Q1 = 2'b00,
      CBU_Q2 = 2'b01,
      CBU_Q3 = 2'b10,
      CBU_Q4 = 2'b11
   } cbu_phase_e;
   typedef enum logic [1:0] {
      CBU_IDLE = 2'b00,
      CBU_EXEC = 2'b01,
      CBU_BUBBLE = 2'b10
   } cbu_state_e;
endpackage

// ---- src/cbu_cond_eval.sv ----
// Purpose: Match branch opcode and evaluate its flag condition
// Assumes: Flags arrive from the same clock domain
// Notes: Pure combinational
`timescale 1ns/10ps
`include "cbu_defines.svh"
module cbu_cond_eval (
   input wire logic [7:0] op_hi,
   input wire logic [3:0] flags,
   output logic is_branch,
   output logic cond_true
);
   wire logic m_n = (op_hi == `CBU_OP_NEG_SET);
   wire logic m_c = (op_hi == `CBU_OP_CARRY_CLR);
   wire logic m_nn = (op_hi == `CBU_OP_NEG_CLR);
   wire logic m_ov = (op_hi == `CBU_OP_OVF_CLR);
   wire logic m_z = (op_hi == `CBU_OP_ZERO_CLR);
   assign is_branch = m_n | m_c | m_nn | m_ov | m_z;
   assign cond_true = (m_n & flags[`CBU_FLAG_N])
      | (m_c & ~flags[`CBU_FLAG_C])
      | (m_nn & ~flags[`CBU_FLAG_N])
      | (m_ov & ~flags[`CBU_FLAG_OV])
      | (m_z & ~flags[`CBU_FLAG_Z]);
endmodule // cbu_cond_eval

// ---- src/cbu_branch_unit.sv ----
// Purpose: Decode and execute flag-conditioned relative branches
// Assumes: Core presents instruction and its address at Q1 with insn_valid
// Notes: Requests seen while busy are dropped; flags are read once, in Q3
`timescale 1ns/10ps
`include "cbu_defines.svh"
module cbu_branch_unit (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic insn_valid,
   input wire logic [15:0] insn_word,
   input wire logic [`CBU_PC_W-1:0] insn_addr,
   input wire logic [3:0] status_flags,
   output logic busy,
   output logic is_branch,
   output logic pc_write,
   output logic [`CBU_PC_W-1:0] pc_next,
   output logic cycle_done,
   output logic bubble,
   output logic [1:0] phase
);
   cbu_pkg::cbu_state_e state_reg, state_next;
   logic [1:0] phase_reg;
   logic [7:0] op_reg;
   logic [7:0] lit_reg;
   logic [`CBU_PC_W-1:0] addr_reg;
   logic taken_reg;
   logic pc_write_reg;
   logic [`CBU_PC_W-1:0] pc_next_reg;
   logic dec_branch;
   logic dec_cond;
   // Flags are only read, never driven: no flag output exists
   cbu_cond_eval u_eval (
      .op_hi(op_reg),
      .flags(status_flags),
      .is_branch(dec_branch),
      .cond_true(dec_cond)
   );
   // Group decode on the raw word; the evaluator sees only the latched copy
   wire logic [7:0] op_in = insn_word[15:8];
   wire logic op_in_branch = op_in inside {`CBU_OP_NEG_SET, `CBU_OP_CARRY_CLR,
      `CBU_OP_NEG_CLR, `CBU_OP_OVF_CLR, `CBU_OP_ZERO_CLR};
   wire logic idle = (state_reg == cbu_pkg::CBU_IDLE);
   // Requests while busy are dropped, not queued: the core must stall fetch
   wire logic start = idle && insn_valid && op_in_branch;
   wire logic exec_q3 = (state_reg == cbu_pkg::CBU_EXEC) && (phase_reg == cbu_pkg::CBU_Q3);
   // Flags are sampled only here, so a flag update in Q4 cannot steer this branch
   wire logic taken_now = dec_branch & dec_cond;
   wire logic last_phase = (phase_reg == `CBU_PHASES);
   // Sign-extend then double the offset
   wire logic [`CBU_PC_W-1:0] offs2 = {{(`CBU_PC_W-9){lit_reg[7]}}, lit_reg, 1'b0};
   wire logic [`CBU_PC_W-1:0] fall_addr = addr_reg + `CBU_WORD_BYTES;
   wire logic [`CBU_PC_W-1:0] jump_addr = fall_addr + offs2;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         cbu_pkg::CBU_IDLE: begin
            if (start) begin
               state_next = cbu_pkg::CBU_EXEC;
            end
         end
         cbu_pkg::CBU_EXEC: begin
            if (last_phase) begin
               // Taken branch pays one whole no-op cycle; the word fetched behind it is dropped
               state_next = taken_reg ? cbu_pkg::CBU_BUBBLE : cbu_pkg::CBU_IDLE;
            end
         end
         cbu_pkg::CBU_BUBBLE: begin
            if (last_phase) begin
               state_next = cbu_pkg::CBU_IDLE;
            end
         end
         default: state_next = cbu_pkg::CBU_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= cbu_pkg::CBU_IDLE;
         phase_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         phase_reg <= (state_reg == cbu_pkg::CBU_IDLE) ? 2'h0 : phase_reg + 2'h1;
      end
   end

   // Q1 decode latches opcode and literal together, Q3 evaluates flags
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         op_reg <= 8'h00;
         lit_reg <= 8'h00;
         addr_reg <= `CBU_PC_RST;
         taken_reg <= 1'b0;
      end else if (start) begin
         op_reg <= insn_word[15:8];
         lit_reg <= insn_word[7:0];
         addr_reg <= insn_addr;
         taken_reg <= 1'b0;
      end else if (exec_q3) begin
         taken_reg <= taken_now;
      end
   end

   // Q4 writes target if taken, else next word
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pc_write_reg <= 1'b0;
         pc_next_reg <= `CBU_PC_RST;
      end else if (exec_q3) begin
         pc_write_reg <= 1'b1;
         pc_next_reg <= taken_now ? jump_addr : fall_addr;
      end else begin
         // Target is kept between writes so the core may read it late
         pc_write_reg <= 1'b0;
      end
   end

   // Handshake outputs decode straight from state; data outputs are registered
   assign busy = (state_reg != cbu_pkg::CBU_IDLE);
   assign is_branch = busy;
   assign pc_write = pc_write_reg;
   assign pc_next = pc_next_reg;
   assign phase = phase_reg;
   assign bubble = (state_reg == cbu_pkg::CBU_BUBBLE);
   assign cycle_done = busy && last_phase && state_next == cbu_pkg::CBU_IDLE;

   // Cycle-length, target and branch-decision checks
   sequence taken_seq;
      state_reg == cbu_pkg::CBU_EXEC && last_phase && taken_reg;
   endsequence
   sequence bubble_seq;
      bubble [*4];
   endsequence
   taken_bubble_a: assert property (@(posedge clk_sys) disable iff (rst)
      taken_seq |=> bubble_seq ##1 !busy)
      else $error("Taken branch lacks one idle cycle");
   not_taken_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_reg == cbu_pkg::CBU_EXEC && last_phase && !taken_reg) |=> !busy)
      else $error("Untaken branch took extra cycle");
   start_len_a: assert property (@(posedge clk_sys) disable iff (rst)
      start |=> busy [*4])
      else $error("Branch cycle shorter than four phases");
   pc_q4_a: assert property (@(posedge clk_sys) disable iff (rst)
      pc_write |-> (phase == 2'h3 && state_reg == cbu_pkg::CBU_EXEC))
      else $error("PC written outside Q4");
   target_a: assert property (@(posedge clk_sys) disable iff (rst)
      (pc_write && taken_reg) |-> pc_next == addr_reg + `CBU_WORD_BYTES + offs2)
      else $error("Wrong branch target");
   fall_thru_a: assert property (@(posedge clk_sys) disable iff (rst)
      (pc_write && !taken_reg) |-> pc_next == addr_reg + `CBU_WORD_BYTES)
      else $error("Wrong fall-through address");
   neg_set_a: assert property (@(posedge clk_sys) disable iff (rst)
      (pc_write && op_reg == `CBU_OP_NEG_SET) |-> taken_reg == $past(status_flags[`CBU_FLAG_N]))
      else $error("Negative-set branch decision wrong");
   carry_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
      (pc_write && op_reg == `CBU_OP_CARRY_CLR) |-> taken_reg == !$past(status_flags[`CBU_FLAG_C]))
      else $error("Carry-clear branch decision wrong");
   neg_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
      (pc_write && op_reg == `CBU_OP_NEG_CLR) |-> taken_reg == !$past(status_flags[`CBU_FLAG_N]))
      else $error("Negative-clear branch decision wrong");
   ovf_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
      (pc_write && op_reg == `CBU_OP_OVF_CLR) |-> taken_reg == !$past(status_flags[`CBU_FLAG_OV]))
      else $error("Overflow-clear branch decision wrong");
   zero_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
      (pc_write && op_reg == `CBU_OP_ZERO_CLR) |-> taken_reg == !$past(status_flags[`CBU_FLAG_Z]))
      else $error("Zero-clear branch decision wrong");

   // Operand, phase and strobe checks
   sequence walk_seq;
      phase == 2'h0 ##1 phase == 2'h1 ##1 phase == 2'h2 ##1 phase == 2'h3;
   endsequence
   phase_walk_a: assert property (@(posedge clk_sys) disable iff (rst)
      start |=> walk_seq)
      else $error("Branch phases out of order");
   bubble_walk_a: assert property (@(posedge clk_sys) disable iff (rst)
      taken_seq |=> walk_seq)
      else $error("No-op cycle phases out of order");
   idle_phase_a: assert property (@(posedge clk_sys) disable iff (rst)
      !busy |-> phase == 2'h0)
      else $error("Phase moved while idle");
   lit_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
      start |=> (lit_reg == $past(insn_word[7:0]) && addr_reg == $past(insn_addr)
         && op_reg == $past(insn_word[15:8])))
      else $error("Branch operands not captured at decode");
   operand_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      (busy && $past(busy)) |-> ($stable(lit_reg) && $stable(addr_reg) && $stable(op_reg)))
      else $error("Branch operands changed while busy");
   decode_busy_a: assert property (@(posedge clk_sys) disable iff (rst)
      busy |-> dec_branch)
      else $error("Busy without a branch opcode latched");
   start_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      start |=> (!taken_reg && !pc_write))
      else $error("Stale decision carried into a new branch");
   pc_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
      pc_write |=> !pc_write)
      else $error("PC write longer than one phase");
   pc_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!pc_write && !$past(rst)) |-> $stable(pc_next))
      else $error("PC target changed without a write");
   bubble_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
      bubble |-> (!pc_write && taken_reg))
      else $error("No-op cycle did work");
   done_q4_a: assert property (@(posedge clk_sys) disable iff (rst)
      cycle_done |-> (phase == 2'h3 && busy))
      else $error("Cycle end flagged outside Q4");
   done_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
      cycle_done |=> !busy)
      else $error("Busy after last cycle ended");
endmodule // cbu_branch_unit

// ---- test/cbu_branch_unit_test.sv ----
// Purpose: Self-checking bench for the conditional branch unit
// Assumes: One phase per clk_sys edge, flags held steady through each branch
// Notes: Corner sweep of every opcode and flag sense, then seeded random traffic
`timescale 1ns/10ps
`include "cbu_defines.svh"
module cbu_branch_unit_test;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic insn_valid = 1'b0;
   logic [15:0] insn_word = 16'h0000;
   logic [`CBU_PC_W-1:0] insn_addr = 21'h000000;
   logic [3:0] status_flags = 4'h0;
   logic busy, is_branch, pc_write, cycle_done, bubble;
   logic [`CBU_PC_W-1:0] pc_next;
   logic [1:0] phase;
   int failures = 0;
   int comparisons = 0;
   logic hung = 1'b0;
   logic [31:0] seed = 32'h0000CBAB;
   logic [7:0] ops [5] = '{`CBU_OP_NEG_SET, `CBU_OP_CARRY_CLR, `CBU_OP_NEG_CLR, `CBU_OP_OVF_CLR, `CBU_OP_ZERO_CLR};
   always #2 clk_sys = ~clk_sys;
   cbu_branch_unit cbu_branch_unit_i (.clk_sys(clk_sys), .rst(rst), .insn_valid(insn_valid),
      .insn_word(insn_word), .insn_addr(insn_addr), .status_flags(status_flags), .busy(busy),
      .is_branch(is_branch), .pc_write(pc_write), .pc_next(pc_next), .cycle_done(cycle_done),
      .bubble(bubble), .phase(phase));
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic exp_taken(input logic [7:0] op, input logic [3:0] fl);
      case (op)
         `CBU_OP_NEG_SET: return fl[`CBU_FLAG_N];
         `CBU_OP_CARRY_CLR: return !fl[`CBU_FLAG_C];
         `CBU_OP_NEG_CLR: return !fl[`CBU_FLAG_N];
         `CBU_OP_OVF_CLR: return !fl[`CBU_FLAG_OV];
         default: return !fl[`CBU_FLAG_Z];
      endcase
   endfunction
   task automatic summarize();
      if (failures == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk_bit(input string name, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %0b seen %0b", name, exp, got);
      end
   endtask
   task automatic chk_pc(input string name, input logic [20:0] exp, input logic [20:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic run_branch(input logic [7:0] op, input logic [7:0] off, input logic [20:0] addr,
      input logic [3:0] fl, input logic hold);
      int n;
      logic tk;
      logic [20:0] tgt;
      tk = exp_taken(op, fl);
      tgt = addr + `CBU_WORD_BYTES + {{12{off[7]}}, off, 1'b0};
      @(posedge clk_sys);
      insn_valid <= 1'b1;
      insn_word <= {op, off};
      insn_addr <= addr;
      status_flags <= fl;
      @(posedge clk_sys);
      // A request held up while busy must be ignored
      insn_valid <= hold;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1 n++;
      end while (pc_write !== 1'b1 && n < 20);
      insn_valid <= 1'b0;
      if (pc_write !== 1'b1) begin
         failures++;
         hung = 1'b1;
      end else begin
         chk_bit("pc_write_in_q4", 1'b1, n == 3 && phase == 2'h3);
         chk_bit("is_branch", 1'b1, is_branch);
         chk_pc("pc_next", tk ? tgt : addr + `CBU_WORD_BYTES, pc_next);
         chk_bit("cycle_done", !tk, cycle_done);
         n = 0;
         do begin
            @(posedge clk_sys);
            #1 n++;
            if (n == 1) chk_bit("bubble", tk, bubble);
            if (n == 1) chk_bit("pc_write_pulse", 1'b0, pc_write);
            if (n == 4) chk_bit("cycle_done_bubble", 1'b1, cycle_done);
         end while (busy !== 1'b0 && n < 20);
         chk_bit("busy_length", 1'b1, n == (tk ? 5 : 1));
         if (busy !== 1'b0) begin
            failures++;
            hung = 1'b1;
         end
      end
   endtask
   initial begin
      logic [31:0] r_op, r_off, r_addr, r_fl;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      #1 chk_pc("pc_next_reset", 21'h000000, pc_next);
      chk_bit("busy_reset", 1'b0, busy);
      // Neighbouring opcode outside the group must not start a cycle
      repeat (3) begin
         @(posedge clk_sys);
         insn_valid <= 1'b1;
         insn_word <= 16'hE205;
         #1 chk_bit("busy_ignored", 1'b0, busy);
         chk_bit("is_branch_ignored", 1'b0, is_branch);
      end
      // Reset in the middle of a taken branch drops it at once
      @(posedge clk_sys);
      insn_word <= {`CBU_OP_NEG_SET, 8'h10};
      status_flags <= 4'hF;
      @(posedge clk_sys);
      insn_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      #1 chk_bit("busy_mid_reset", 1'b0, busy);
      chk_bit("pc_write_mid_reset", 1'b0, pc_write);
      chk_bit("phase_mid_reset", 1'b1, phase == 2'h0);
      chk_pc("pc_next_mid_reset", 21'h000000, pc_next);
      for (int k = 0; k < 10 && !hung; k++) begin
         run_branch(ops[k / 2], k[0] ? 8'h80 : 8'h7F, 21'h1FFFFE, k[0] ? 4'hF : 4'h0, k[1]);
      end
      for (int k = 0; k < 30 && !hung; k++) begin
         r_op = xorshift();
         r_off = xorshift();
         r_addr = xorshift();
         r_fl = xorshift();
         run_branch(ops[r_op % 5], r_off[7:0], r_addr[20:0], r_fl[3:0], r_fl[4]);
      end
      summarize();
   end
endmodule // cbu_branch_unit_test
